/* common/rct_pkg.sv */
// constants, register layout and channel state of the reload/capture timer
// How it works
// [R1] 16-bit count, two identical timer channels
// [R2] modes: auto-reload or single-channel capture
// [R3] timer mode advances once per twelve clocks
// [R4] counter mode advances on count pin falls
// [R5] source keeps count pin slower than clock/24
// [R6] up count: reload value upward, overflow, reload
// [R7] reload by overflow, optionally trigger edge too
// [R8] reload value comes from reload/capture register
// [R9] every plain reload event raises the request
// [R10] up/down: trigger pin level picks direction
// [R11] up/down counting raises no request
// [R12] down: from all ones to reload value
// [R13] capture mode counts up, wraps to zero
// [R14] selected trigger edge is the capture event
// [R15] capture copies count into reload/capture register
// [R16] capture mode: overflow and capture both raise request
// [R17] pins synchronised before edge or level detection
`default_nettype none
package rct_pkg;
    localparam int              CNT_W     = 16;
    localparam logic [15:0]     CNT_MAX   = 16'hFFFF;
    localparam logic [15:0]     CNT_ZERO  = 16'h0000;
    localparam int              DIV_W     = 4;
    localparam logic [3:0]      DIV_LAST  = 4'hB;
    localparam int              ADDR_W    = 8;
    localparam int              CH_LSB    = 5;
    localparam int              CH_W      = 3;
    localparam int              REG_LSB   = 2;
    localparam int              REG_W     = 3;
    localparam logic [2:0]      REG_CTRL  = 3'h0;
    localparam logic [2:0]      REG_STAT  = 3'h1;
    localparam logic [2:0]      REG_RELOAD = 3'h2;
    localparam logic [2:0]      REG_COUNT = 3'h3;
    localparam int              CTRL_W    = 6;
    localparam int              STAT_OVF  = 0;
    localparam int              STAT_EXT  = 1;

    // bit 0 run ... bit 5 updown
    typedef struct packed {
        logic updown;
        logic rising;
        logic ext_en;
        logic capture;
        logic counter;
        logic run;
    } ctrl_t;

    typedef struct packed {
        ctrl_t              ctrl;
        logic [CNT_W-1:0]   timer_count_value;
        logic [CNT_W-1:0]   reload_capture_value;
        logic [DIV_W-1:0]   div;
        logic               f_ovf;
        logic               f_ext;
        logic               irq;
    } chan_t;

    localparam chan_t CHAN_RESET = '0;
endpackage : rct_pkg
`default_nettype wire

/* common/pin_event_if.sv */
// synchronised pin levels and edge pulses of one timer channel
`default_nettype none
interface pin_event_if;
    logic count_fall;
    logic trig_rise;
    logic trig_fall;
    logic trig_level;
    modport src (output count_fall, output trig_rise, output trig_fall, output trig_level);
    modport dst (input count_fall, input trig_rise, input trig_fall, input trig_level);
endinterface : pin_event_if
`default_nettype wire

/* verilog/pin_event_sync.sv */
// two-stage synchroniser and edge detector for count and trigger pins
`default_nettype none
module pin_event_sync (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       count_input_pin,
    input  wire logic       external_trigger_pin,
    pin_event_if.src        ev
);
    typedef struct packed {
        logic cnt_s1;
        logic cnt_s2;
        logic cnt_prev;
        logic trg_s1;
        logic trg_s2;
        logic trg_prev;
    } sync_t;

    sync_t s_q;
    sync_t s_d;

    always_comb begin
        s_d          = s_q;
        s_d.cnt_s1   = count_input_pin;
        s_d.cnt_s2   = s_q.cnt_s1;
        s_d.cnt_prev = s_q.cnt_s2;
        s_d.trg_s1   = external_trigger_pin;
        s_d.trg_s2   = s_q.trg_s1;
        s_d.trg_prev = s_q.trg_s2;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // edges seen only after the second stage
    assign ev.count_fall = s_q.cnt_prev & ~s_q.cnt_s2; // R17
    assign ev.trig_rise  = ~s_q.trg_prev & s_q.trg_s2;
    assign ev.trig_fall  = s_q.trg_prev & ~s_q.trg_s2;
    assign ev.trig_level = s_q.trg_s2;

    property p_fall_once;
        @(posedge pclk) disable iff (!presetn)
        ev.count_fall |=> !ev.count_fall;
    endproperty
    a_fall_once: assert property (p_fall_once) else $error("count fall pulse too long"); // R17

    property p_trig_delay;
        @(posedge pclk) disable iff (!presetn)
        $rose(external_trigger_pin) ##1 external_trigger_pin ##1 external_trigger_pin
            |-> ev.trig_rise || $past(ev.trig_rise);
    endproperty
    a_trig_delay: assert property (p_trig_delay) else $error("trigger rise not seen"); // R17
endmodule : pin_event_sync
`default_nettype wire

/* verilog/reload_capture_timer16.sv */
// apb slave with independent 16-bit reload/capture timer channels
`default_nettype none
module reload_capture_timer16 #(
    parameter int CHANNELS = 2
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [rct_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [CHANNELS-1:0]        count_input_pin,
    input  wire logic [CHANNELS-1:0]        external_trigger_pin,
    output logic [CHANNELS-1:0]             timer_irq
);
    import rct_pkg::*;

    // elaboration check on the channel count
    if (CHANNELS < 1 || CHANNELS > (1 << CH_W)) begin : g_bad_channels
        $error("CHANNELS out of range");
    end

    typedef struct packed {
        chan_t [CHANNELS-1:0]   ch;
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
    } state_t;

    state_t                 s_q;
    state_t                 s_d;
    logic [CHANNELS-1:0]    cfall;
    logic [CHANNELS-1:0]    trise;
    logic [CHANNELS-1:0]    tfall;
    logic [CHANNELS-1:0]    tlevel;

    // one synchroniser per channel
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_ch // R1
            pin_event_if ev ();
            pin_event_sync u_sync (
                .pclk                 (pclk),
                .presetn              (presetn),
                .count_input_pin      (count_input_pin[g]),
                .external_trigger_pin (external_trigger_pin[g]),
                .ev                   (ev.src)
            );
            assign cfall[g]  = ev.count_fall;
            assign trise[g]  = ev.trig_rise;
            assign tfall[g]  = ev.trig_fall;
            assign tlevel[g] = ev.trig_level;
        end
    endgenerate

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic [REG_W-1:0] r;
        r = a[REG_LSB +: REG_W];
        return (32'(a[CH_LSB +: CH_W]) < CHANNELS) && (r <= REG_COUNT)
               && (a[REG_LSB-1:0] == 2'h0);
    endfunction : mapped

    function automatic logic [31:0] rd(input chan_t c, input logic [REG_W-1:0] r);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (r)
            REG_CTRL:   v[CTRL_W-1:0] = c.ctrl;
            REG_STAT:   v[STAT_EXT:STAT_OVF] = {c.f_ext, c.f_ovf};
            REG_RELOAD: v[CNT_W-1:0] = c.reload_capture_value;
            REG_COUNT:  v[CNT_W-1:0] = c.timer_count_value;
            default:    v = 32'h0000_0000;
        endcase
        return v;
    endfunction : rd

    function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v);
        return v + 16'h0001;
    endfunction : inc

    // one clock of a channel; flags in the result are this cycle's events only
    function automatic chan_t step(input chan_t c, input logic cf, input logic tr,
                                  input logic tf, input logic tl);
        chan_t n;
        logic  tick;
        logic  trig;
        n       = c;
        n.f_ovf = 1'b0;
        n.f_ext = 1'b0;
        n.div   = (c.div == DIV_LAST) ? '0 : c.div + 4'h1;
        tick    = c.ctrl.counter ? cf : (c.div == DIV_LAST); // R3 R4
        trig    = c.ctrl.ext_en & (c.ctrl.rising ? tr : tf);
        if (c.ctrl.run) begin
            if (c.ctrl.capture) begin // R2
                if (tick) begin
                    if (c.timer_count_value == CNT_MAX) begin
                        n.timer_count_value = CNT_ZERO; // R13
                        n.f_ovf = 1'b1; // R16
                    end else begin
                        n.timer_count_value = inc(c.timer_count_value);
                    end
                end
                if (trig) begin // R14
                    n.reload_capture_value = c.timer_count_value; // R15
                    n.f_ext = 1'b1; // R16
                end
            end else if (c.ctrl.updown) begin // R11
                if (tick && tl) begin // R10
                    n.timer_count_value = (c.timer_count_value == CNT_MAX)
                        ? c.reload_capture_value : inc(c.timer_count_value);
                end else if (tick) begin
                    n.timer_count_value = (c.timer_count_value == c.reload_capture_value)
                        ? CNT_MAX : c.timer_count_value - 16'h0001; // R12
                end
            end else if (trig) begin
                n.timer_count_value = c.reload_capture_value; // R7 R8
                n.f_ext = 1'b1; // R9
            end else if (tick) begin
                if (c.timer_count_value == CNT_MAX) begin
                    n.timer_count_value = c.reload_capture_value; // R6 R8
                    n.f_ovf = 1'b1; // R9
                end else begin
                    n.timer_count_value = inc(c.timer_count_value);
                end
            end
        end
        return n;
    endfunction : step

    logic                setup;
    logic                wr_acc;
    logic [CH_W-1:0]     sel_ch;
    logic [REG_W-1:0]    sel_reg;

    assign setup   = psel & ~penable;
    assign wr_acc  = psel & penable & s_q.pready & pwrite & ~s_q.pslverr;
    assign sel_ch  = paddr[CH_LSB +: CH_W];
    assign sel_reg = paddr[REG_LSB +: REG_W];

    always_comb begin
        chan_t n;
        logic  hit;
        n         = CHAN_RESET;
        hit       = 1'b0;
        s_d       = s_q;
        s_d.pready = setup;
        if (setup) begin
            s_d.pslverr = ~mapped(paddr);
            s_d.prdata  = 32'h0000_0000;
            for (int i = 0; i < CHANNELS; i++) begin
                if (32'(sel_ch) == i && mapped(paddr)) begin
                    s_d.prdata = rd(s_q.ch[i], sel_reg);
                end
            end
        end
        for (int i = 0; i < CHANNELS; i++) begin
            n   = step(s_q.ch[i], cfall[i], trise[i], tfall[i], tlevel[i]);
            hit = wr_acc && (32'(sel_ch) == i);
            s_d.ch[i] = n;
            s_d.ch[i].f_ovf = s_q.ch[i].f_ovf;
            s_d.ch[i].f_ext = s_q.ch[i].f_ext;
            if (hit) begin
                unique case (sel_reg)
                    REG_CTRL:   s_d.ch[i].ctrl = ctrl_t'(pwdata[CTRL_W-1:0]);
                    REG_STAT: begin
                        s_d.ch[i].f_ovf = s_q.ch[i].f_ovf & ~pwdata[STAT_OVF];
                        s_d.ch[i].f_ext = s_q.ch[i].f_ext & ~pwdata[STAT_EXT];
                    end
                    REG_RELOAD: begin
                        // a capture in the same cycle wins over the write
                        if (!(s_q.ch[i].ctrl.capture && n.f_ext)) begin
                            s_d.ch[i].reload_capture_value = pwdata[CNT_W-1:0];
                        end
                    end
                    REG_COUNT:  s_d.ch[i].timer_count_value = pwdata[CNT_W-1:0];
                    default:    s_d.ch[i].ctrl = s_q.ch[i].ctrl;
                endcase
            end
            // events set after the clear so they are never lost
            s_d.ch[i].f_ovf = s_d.ch[i].f_ovf | n.f_ovf;
            s_d.ch[i].f_ext = s_d.ch[i].f_ext | n.f_ext;
            s_d.ch[i].irq   = s_d.ch[i].f_ovf | s_d.ch[i].f_ext; // R9 R16
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata  = s_q.prdata;
    assign pready  = s_q.pready;
    assign pslverr = s_q.pslverr;
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            timer_irq[i] = s_q.ch[i].irq;
        end
    end

    // checks on channel 0 and on the apb handshake
    chan_t c0;
    logic  tick0;
    logic  trig0;
    logic  idle0;
    assign c0    = s_q.ch[0];
    assign tick0 = c0.ctrl.counter ? cfall[0] : (c0.div == DIV_LAST);
    assign trig0 = c0.ctrl.ext_en & (c0.ctrl.rising ? trise[0] : tfall[0]);
    assign idle0 = c0.ctrl.run & ~wr_acc;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_timer_rate;
        idle0 && !c0.ctrl.counter && !c0.ctrl.capture && !c0.ctrl.updown && !trig0
            && c0.div == DIV_LAST && c0.timer_count_value != CNT_MAX
            |=> c0.timer_count_value == inc($past(c0.timer_count_value));
    endproperty
    a_timer_rate: assert property (p_timer_rate) else $error("no step after 12 clocks"); // R3

    property p_timer_hold;
        idle0 && !c0.ctrl.counter && c0.div != DIV_LAST && !trig0
            |=> $stable(c0.timer_count_value);
    endproperty
    a_timer_hold: assert property (p_timer_hold) else $error("count moved between ticks"); // R3

    property p_counter_fall;
        idle0 && c0.ctrl.counter && !c0.ctrl.capture && !c0.ctrl.updown && !trig0
            && cfall[0] && c0.timer_count_value != CNT_MAX
            |=> c0.timer_count_value == inc($past(c0.timer_count_value));
    endproperty
    a_counter_fall: assert property (p_counter_fall) else $error("pin fall not counted"); // R4

    property p_overflow_reload;
        idle0 && !c0.ctrl.capture && !c0.ctrl.updown && !trig0 && tick0
            && c0.timer_count_value == CNT_MAX
            |=> c0.timer_count_value == $past(c0.reload_capture_value) && c0.f_ovf
                && timer_irq[0];
    endproperty
    a_overflow_reload: assert property (p_overflow_reload) else $error("bad reload"); // R6

    property p_trig_reload;
        idle0 && !c0.ctrl.capture && !c0.ctrl.updown && trig0
            |=> c0.timer_count_value == $past(c0.reload_capture_value) && c0.f_ext;
    endproperty
    a_trig_reload: assert property (p_trig_reload) else $error("trigger reload missed"); // R7

    property p_up_dir;
        idle0 && !c0.ctrl.capture && c0.ctrl.updown && tlevel[0] && tick0
            && c0.timer_count_value != CNT_MAX
            |=> c0.timer_count_value == inc($past(c0.timer_count_value));
    endproperty
    a_up_dir: assert property (p_up_dir) else $error("high level did not count up"); // R10

    property p_updown_quiet;
        idle0 && !c0.ctrl.capture && c0.ctrl.updown |=> !$rose(c0.f_ovf) && !$rose(c0.f_ext);
    endproperty
    a_updown_quiet: assert property (p_updown_quiet) else $error("up/down set a flag"); // R11

    property p_down_under;
        idle0 && !c0.ctrl.capture && c0.ctrl.updown && !tlevel[0] && tick0
            && c0.timer_count_value == c0.reload_capture_value
            |=> c0.timer_count_value == CNT_MAX;
    endproperty
    a_down_under: assert property (p_down_under) else $error("underflow not reloaded"); // R12

    property p_capture_wrap;
        idle0 && c0.ctrl.capture && tick0 && c0.timer_count_value == CNT_MAX
            |=> c0.timer_count_value == CNT_ZERO && c0.f_ovf;
    endproperty
    a_capture_wrap: assert property (p_capture_wrap) else $error("capture wrap wrong"); // R13

    property p_capture_copy;
        idle0 && c0.ctrl.capture && trig0
            |=> c0.reload_capture_value == $past(c0.timer_count_value) && c0.f_ext
                && timer_irq[0];
    endproperty
    a_capture_copy: assert property (p_capture_copy) else $error("capture not stored"); // R15

    property p_unmapped;
        setup && !mapped(paddr) |=> pready && pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");

    property p_mapped_ok;
        setup && mapped(paddr) |=> pready && !pslverr;
    endproperty
    a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused");

    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

    property p_read_count;
        setup && mapped(paddr) && sel_ch == '0 && sel_reg == REG_COUNT
            |=> prdata == {16'h0000, $past(c0.timer_count_value)};
    endproperty
    a_read_count: assert property (p_read_count) else $error("count read wrong"); // R1

    property p_stopped;
        !c0.ctrl.run && !wr_acc |=> $stable(c0.timer_count_value);
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped count moved");

    property p_down_step;
        idle0 && !c0.ctrl.capture && c0.ctrl.updown && !tlevel[0] && tick0
            && c0.timer_count_value != c0.reload_capture_value
            |=> c0.timer_count_value == $past(c0.timer_count_value) - 16'h0001;
    endproperty
    a_down_step: assert property (p_down_step) else $error("low level did not count down"); // R10

    property p_capture_count;
        idle0 && c0.ctrl.capture && tick0 && c0.timer_count_value != CNT_MAX
            |=> c0.timer_count_value == inc($past(c0.timer_count_value));
    endproperty
    a_capture_count: assert property (p_capture_count) else $error("capture count stuck"); // R13

    property p_capture_hold;
        idle0 && c0.ctrl.capture && !trig0 |=> $stable(c0.reload_capture_value);
    endproperty
    a_capture_hold: assert property (p_capture_hold) else $error("capture without edge"); // R14

    property p_trig_irq;
        idle0 && !c0.ctrl.capture && !c0.ctrl.updown && trig0 |=> timer_irq[0];
    endproperty
    a_trig_irq: assert property (p_trig_irq) else $error("reload raised no request"); // R9

    property p_capture_irq;
        idle0 && c0.ctrl.capture
            && (trig0 || (tick0 && c0.timer_count_value == CNT_MAX)) |=> timer_irq[0];
    endproperty
    a_capture_irq: assert property (p_capture_irq) else $error("capture raised no request"); // R16

    property p_updown_no_irq;
        idle0 && !c0.ctrl.capture && c0.ctrl.updown && !timer_irq[0] |=> !timer_irq[0];
    endproperty
    a_updown_no_irq: assert property (p_updown_no_irq) else $error("up/down raised request"); // R11
endmodule : reload_capture_timer16
`default_nettype wire

/* sim/pin_source.sv */
// behavioural source for the count and trigger pins of each timer channel
`default_nettype none
module pin_source #(
    parameter int CHANNELS = 2
) (
    input  wire logic                pclk,
    output logic [CHANNELS-1:0]      count_input_pin,
    output logic [CHANNELS-1:0]      external_trigger_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        count_input_pin = '1;
        external_trigger_pin = '0;
    end

    // falls spaced 25 clocks apart, low phase of 12 clocks, high phase of 13
    task automatic count_falls(input int ch, input int n);
        repeat (n) begin
            @(posedge pclk);
            count_input_pin[ch] <= 1'b0;
            repeat (12) @(posedge pclk);
            count_input_pin[ch] <= 1'b1;
            repeat (12) @(posedge pclk);
        end
    endtask : count_falls

    // level change, then time for the synchroniser to settle
    task automatic set_trigger(input int ch, input logic lvl);
        @(posedge pclk);
        external_trigger_pin[ch] <= lvl;
        repeat (6) @(posedge pclk);
    endtask : set_trigger
endmodule : pin_source
`default_nettype wire

/* sim/test_reload_capture_timer16.sv */
// self-checking bench for the reload/capture timer over apb
`default_nettype none
`define check(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("unexpected at %0t: got %0h, expected %0h", $time, got, exp); \
        end \
    end
module test_reload_capture_timer16;
    timeunit 1ns;
    timeprecision 1ns;
    import rct_pkg::*;

    logic           pclk = 1'b0;
    logic           presetn = 1'b0;
    logic           psel = 1'b0;
    logic           penable = 1'b0;
    logic           pwrite = 1'b0;
    logic [7:0]     paddr = 8'h00;
    logic [31:0]    pwdata = 32'h0;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic [1:0]     count_input_pin;
    logic [1:0]     external_trigger_pin;
    logic [1:0]     timer_irq;
    int             error_cnt = 0;
    int             n_compared = 0;
    integer         seed = 32'hFFA10EBB;
    logic [15:0]    rel;
    logic [31:0]    d;
    logic           e;
    logic           pol;
    int             n;
    logic [7:0]     addr_list [3] = '{8'h40, 8'h10, 8'h01};

    always #50 pclk = ~pclk;

    reload_capture_timer16 #(.CHANNELS(2)) i_reload_capture_timer16 (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .count_input_pin(count_input_pin),
        .external_trigger_pin(external_trigger_pin), .timer_irq(timer_irq)
    );

    pin_source #(.CHANNELS(2)) i_pin_source (
        .pclk(pclk), .count_input_pin(count_input_pin),
        .external_trigger_pin(external_trigger_pin)
    );

    task automatic stop_test();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    function automatic logic [7:0] addr(input int ch, input logic [2:0] r);
        return {3'(ch), r, 2'b00};
    endfunction : addr

    // expected count after n ticks in the given direction and mode
    function automatic logic [15:0] step_count(input logic [15:0] c, input logic [15:0] r,
                                               input logic up, input logic cap, input int n);
        for (int i = 0; i < n; i++) begin
            if (up) begin
                c = (c == CNT_MAX) ? (cap ? CNT_ZERO : r) : c + 16'h0001;
            end else begin
                c = (c == r) ? CNT_MAX : c - 16'h0001;
            end
        end
        return c;
    endfunction : step_count

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("unexpected at %0t: no ready", $time);
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input int ch, input logic [2:0] r, input logic [31:0] v);
        logic [31:0] x;
        logic        er;
        apb(1'b1, addr(ch, r), v, x, er);
        `check(er, 1'b0)
    endtask : wr

    task automatic rd_chk(input int ch, input logic [2:0] r, input logic [31:0] exp);
        logic [31:0] x;
        logic        er;
        apb(1'b0, addr(ch, r), 32'h0, x, er);
        `check(er, 1'b0)
        `check(x, exp)
    endtask : rd_chk

    task automatic setup(input int ch, input logic [15:0] r, input logic [15:0] c,
                         input logic [31:0] ctrl);
        wr(ch, REG_CTRL, 32'h0);
        wr(ch, REG_RELOAD, {16'h0, r});
        wr(ch, REG_COUNT, {16'h0, c});
        wr(ch, REG_STAT, 32'h3);
        wr(ch, REG_CTRL, ctrl);
    endtask : setup

    initial begin
        repeat (100000) @(posedge pclk);
        error_cnt++;
        $display("unexpected at %0t: run too long", $time);
        stop_test();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        for (int ch = 0; ch < 2; ch++) begin
            for (int r = 0; r < 4; r++) begin
                rd_chk(ch, 3'(r), 32'h0);
            end
        end
        `check(timer_irq, 2'b00)
        // unmapped channel, register index and misaligned address
        foreach (addr_list[i]) begin
            apb(1'b1, addr_list[i], 32'hFFFFFFFF, d, e);
            `check(e, 1'b1)
            apb(1'b0, addr_list[i], 32'h0, d, e);
            `check(e, 1'b1)
            `check(d, 32'h0)
        end
        rd_chk(0, REG_CTRL, 32'h0);
        setup(0, 16'h0000, 16'h0000, 32'h01);
        repeat (240) @(posedge pclk);
        apb(1'b0, addr(0, REG_COUNT), 32'h0, d, e);
        `check(d >= 32'd19 && d <= 32'd21, 1'b1)
        for (int k = 0; k < 3; k++) begin
            rel = 16'($random(seed));
            n = k + 2;
            setup(0, rel, 16'hFFFD, 32'h03);
            i_pin_source.count_falls(0, n);
            rd_chk(0, REG_COUNT, {16'h0, step_count(16'hFFFD, rel, 1'b1, 1'b0, n)});
            rd_chk(0, REG_STAT, {31'h0, n > 2});
            `check(timer_irq[0], n > 2)
        end
        wr(0, REG_STAT, 32'h1);
        rd_chk(0, REG_STAT, 32'h0);
        `check(timer_irq[0], 1'b0)
        pol = 1'($random(seed));
        // both trigger polarities, random one first
        for (int j = 0; j < 2; j++) begin
            pol = ~pol;
            i_pin_source.set_trigger(0, ~pol);
            setup(0, rel, 16'h1234, 32'h0B | (pol ? 32'h10 : 32'h0));
            rd_chk(0, REG_CTRL, 32'h0B | (pol ? 32'h10 : 32'h0));
            i_pin_source.count_falls(0, 1);
            rd_chk(0, REG_COUNT, 32'h1235);
            i_pin_source.set_trigger(0, pol);
            rd_chk(0, REG_COUNT, {16'h0, rel});
            rd_chk(0, REG_STAT, 32'h2);
            `check(timer_irq[0], 1'b1)
            i_pin_source.count_falls(0, 1);
            i_pin_source.set_trigger(0, ~pol);
            rd_chk(0, REG_COUNT, {16'h0, step_count(rel, rel, 1'b1, 1'b0, 1)});
        end
        rel = {1'b0, 15'($random(seed))};
        i_pin_source.set_trigger(0, 1'b0);
        setup(0, rel, rel + 16'h0002, 32'h23);
        i_pin_source.count_falls(0, 3);
        rd_chk(0, REG_COUNT, {16'h0, step_count(rel + 16'h2, rel, 1'b0, 1'b0, 3)});
        i_pin_source.set_trigger(0, 1'b1);
        i_pin_source.count_falls(0, 1);
        rd_chk(0, REG_COUNT, {16'h0, rel});
        rd_chk(0, REG_STAT, 32'h0);
        `check(timer_irq[0], 1'b0)
        pol = 1'($random(seed));
        for (int j = 0; j < 2; j++) begin
            pol = ~pol;
            n = 2 + ($random(seed) & 32'h3);
            i_pin_source.set_trigger(1, ~pol);
            setup(1, 16'hA5A5, CNT_MAX, 32'h0F | (pol ? 32'h10 : 32'h0));
            i_pin_source.count_falls(1, n);
            rd_chk(1, REG_COUNT, 32'(n - 1));
            i_pin_source.set_trigger(1, pol);
            rd_chk(1, REG_RELOAD, 32'(n - 1));
            rd_chk(1, REG_STAT, 32'h3);
            `check(timer_irq, 2'b10)
            i_pin_source.count_falls(1, 1);
            i_pin_source.set_trigger(1, ~pol);
            rd_chk(1, REG_RELOAD, 32'(n - 1));
        end
        stop_test();
    end
endmodule : test_reload_capture_timer16
`default_nettype wire
